// ==== rtl/acp_port.sv ====
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// ------------------------------------------------------------
module acp_port #(
    parameter int CONV_CYCLES = acp_pkg::CONV_CYC
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        cs_n,
    input  wire logic        rc,
    input  wire logic        byte_sel,
    // Converter core: sample word in two's complement, handshaked
    input  wire logic [15:0] core_code,
    input  wire logic        core_valid,
    output logic             core_ready,
    output logic             hold,
    output logic             busy_n,
    output logic [15:0]      result_bus_o,
    output logic [15:0]      result_bus_oe_n
);

    acp_pkg::acp_ctrl_t sync1;
    acp_pkg::acp_ctrl_t sync2;
    acp_pkg::acp_state_t state;
    logic [acp_pkg::CNT_W-1:0] low_cnt;
    logic [acp_pkg::CNT_W-1:0] conv_cnt;
    logic [15:0] out_reg;
    logic        or_low;
    logic        start_edge;
    logic        start_seen;
    logic        buf_valid;
    logic        buf_ready;
    logic [15:0] buf_data;
    logic        take;
    logic        buf_in_ready;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync1 <= '{cs_n: 1'b1, rc: 1'b1, byte_sel: 1'b0};
            sync2 <= '{cs_n: 1'b1, rc: 1'b1, byte_sel: 1'b0};
        end else begin
            sync1 <= '{cs_n: cs_n, rc: rc, byte_sel: byte_sel};
            sync2 <= sync1;
        end
    end

    // Both controls low: OR of the two lines is low
    assign or_low = !(sync2.cs_n | sync2.rc);

    // combined start
    // One pulse per low period of the OR, once it has lasted the minimum
    // width; either line falling last opens that period
    assign start_edge = or_low && !start_seen
                        && (low_cnt == acp_pkg::CNT_W'(acp_pkg::START_LOW_CYC - 1));

    // ------------------------------------------------------------
    // Low-time qualifier
    // ------------------------------------------------------------
    // minimum low width
    // Glitches shorter than the minimum width never start a conversion
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            low_cnt    <= '0;
            start_seen <= 1'b0;
        end else if (!or_low) begin
            low_cnt    <= '0;
            start_seen <= 1'b0;
        end else if (!start_seen) begin
            if (low_cnt == acp_pkg::CNT_W'(acp_pkg::START_LOW_CYC - 1)) begin
                start_seen <= 1'b1;
            end
            low_cnt <= low_cnt + 1'b1;
        end
    end

    // Core samples into the buffer only on our request; a flop raised with
    // hold and dropped after one word, so no second word joins a conversion
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            core_ready <= 1'b0;
        end else if (core_valid && core_ready) begin
            core_ready <= 1'b0;
        end else if ((state == acp_pkg::ACP_IDLE) && start_edge) begin
            core_ready <= buf_in_ready;
        end else if (state != acp_pkg::ACP_HOLD) begin
            core_ready <= 1'b0;
        end else if (conv_cnt == acp_pkg::CNT_W'(CONV_CYCLES - 1)) begin
            core_ready <= 1'b0;
        end
    end

    acp_buf2 #(
        .W (acp_pkg::RESULT_W)
    ) u_buf (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (core_valid && core_ready),
        .in_ready  (buf_in_ready),
        .in_data   (core_code),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    assign take      = (state == acp_pkg::ACP_LATCH) && buf_valid;
    assign buf_ready = take;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state    <= acp_pkg::ACP_IDLE;
            conv_cnt <= '0;
            hold     <= 1'b0;
            busy_n   <= 1'b1;
        end else begin
            unique case (state)
                acp_pkg::ACP_IDLE: begin
                    if (start_edge) begin
                        state    <= acp_pkg::ACP_HOLD;
                        hold     <= 1'b1;
                        busy_n   <= 1'b0;
                        conv_cnt <= '0;
                    end
                end
                acp_pkg::ACP_HOLD: begin
                    conv_cnt <= conv_cnt + 1'b1;
                    if (conv_cnt == acp_pkg::CNT_W'(CONV_CYCLES - 1)) begin
                        state <= acp_pkg::ACP_LATCH;
                        hold  <= 1'b0;
                    end
                end
                acp_pkg::ACP_LATCH: begin
                    if (take) begin
                        state  <= acp_pkg::ACP_IDLE;
                        busy_n <= 1'b1;
                    end
                end
                default: begin
                    state <= acp_pkg::ACP_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    // two's complement kept
    // reset loads RESULT_RST (all zeros)
    // Core word is already two's complement; stored as is
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            out_reg <= acp_pkg::RESULT_RST;
        end else if (take) begin
            out_reg <= buf_data;
        end
    end

    // ------------------------------------------------------------
    // Result bus drive
    // ------------------------------------------------------------
    // byte order
    // data ready at busy rise
    // Data written the same edge busy rises, so the bus is valid then
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_bus_o <= '0;
        end else if (sync2.byte_sel) begin
            result_bus_o <= {(take ? buf_data[acp_pkg::HALF_W-1:0]
                                   : out_reg[acp_pkg::HALF_W-1:0]),
                             (take ? buf_data[acp_pkg::MSB_POS:acp_pkg::HALF_W]
                                   : out_reg[acp_pkg::MSB_POS:acp_pkg::HALF_W])};
        end else begin
            result_bus_o <= take ? buf_data : out_reg;
        end
    end

    // enable drivers
    // Enable is a level of cs_n low and rc high, so both edges open it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_bus_oe_n <= '1;
        end else begin
            result_bus_oe_n <= {acp_pkg::RESULT_W{sync2.cs_n | !sync2.rc}};
        end
    end

endmodule // acp_port
`default_nettype wire

// ==== rtl/acp_pkg.sv ====
package acp_pkg;

    // ------------------------------------------------------------
    // Widths and layout
    // ------------------------------------------------------------
    localparam int RESULT_W = 16;
    localparam int HALF_W   = 8;
    localparam int MSB_POS  = 15;

    // ------------------------------------------------------------
    // Timing (mclk 100 MHz)
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int START_LOW_NS    = 50;
    // Least time: round up
    localparam int START_LOW_CYC   = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_TIME_NS    = 4000;
    localparam int CONV_CYC        = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W           = 12;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACP_IDLE  = 2'b00,
        ACP_HOLD  = 2'b01,
        ACP_LATCH = 2'b11
    } acp_state_t;

    // Control pins after synchronising
    typedef struct packed {
        logic cs_n;
        logic rc;
        logic byte_sel;
    } acp_ctrl_t;

endpackage : acp_pkg

// ==== rtl/acp_buf2.sv ====
`timescale 1ns/100ps
`default_nettype none

// Two-entry skid buffer; a stalled drain loses no word
module acp_buf2 #(
    parameter int W = 16
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic [W-1:0] mem [2];
    logic         wr_ptr;
    logic         rd_ptr;
    logic [1:0]   count;
    logic         do_wr;
    logic         do_rd;
    logic         next_rd;

    assign do_wr = in_valid && (count != 2'd2);
    assign do_rd = out_ready && (count != 2'd0);

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
        end else begin
            if (do_wr) begin
                wr_ptr <= ~wr_ptr;
            end
            if (do_rd) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, do_wr} - {1'b0, do_rd};
        end
    end

    // Registered read port loads the head word after this edge, a same-edge
    // write included, so out_data is valid in the cycle out_valid rises
    assign next_rd = do_rd ? ~rd_ptr : rd_ptr;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            out_data <= '0;
        end else if (do_wr && (wr_ptr == next_rd)) begin
            out_data <= in_data;
        end else begin
            out_data <= mem[next_rd];
        end
    end

    // Full/empty flags honest from count
    assign in_ready  = (count != 2'd2);
    assign out_valid = (count != 2'd0);

endmodule // acp_buf2
`default_nettype wire

// ==== sim/acp_port_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module acp_port_asserts #(
    parameter int CONV_CYCLES = acp_pkg::CONV_CYC
) (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        cs_n,
    input wire logic        rc,
    input wire logic        byte_sel,
    input wire logic [15:0] core_code,
    input wire logic        core_valid,
    input wire logic        core_ready,
    input wire logic        hold,
    input wire logic        busy_n,
    input wire logic [15:0] result_bus_o,
    input wire logic [15:0] result_bus_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [11:0] hold_cnt;
    logic [15:0] taken;
    // Word the core handed over, to judge the bus at busy rise
    always_ff @(posedge mclk) begin
        if (core_valid && core_ready) begin
            taken <= core_code;
        end
    end
    // Counter, since hold is too long for a repetition
    always_ff @(posedge mclk) begin
        if (sys_rst || !hold) begin
            hold_cnt <= 12'h000;
        end else begin
            hold_cnt <= hold_cnt + 12'h001;
        end
    end
    sequence s_idle_fall;
        busy_n && !hold && $fell(cs_n | rc);
    endsequence
    sequence s_start_req;
        s_idle_fall ##1 !(cs_n | rc) [*4];
    endsequence
    sequence s_nat_rise;
        !byte_sel [*4] ##1 $rose(busy_n);
    endsequence
    sequence s_swap_rise;
        byte_sel [*4] ##1 $rose(busy_n);
    endsequence
    // Five sampled low cycles, two sync stages, then the start edge
    property p_start; s_start_req |-> ##3 (!busy_n && hold); endproperty
    property p_nat; s_nat_rise |-> result_bus_o == taken; endproperty
    property p_swap; s_swap_rise |-> result_bus_o == {taken[7:0], taken[15:8]}; endproperty
    property p_float; (cs_n | !rc) [*5] |-> result_bus_oe_n == 16'hffff; endproperty
    property p_drive; (!cs_n && rc) [*5] |-> result_bus_oe_n == 16'h0000; endproperty
    property p_hold_busy; $rose(hold) |-> !busy_n; endproperty
    property p_latch_wait; $fell(hold) |-> !busy_n; endproperty
    property p_no_restart; !busy_n && !hold |=> !hold; endproperty
    property p_hold_len; $fell(hold) |-> hold_cnt == 12'(CONV_CYCLES); endproperty
    property p_ready; core_ready |-> hold; endproperty
    a_start: assert property (p_start)
        else $error("start not taken");
    a_float: assert property (p_float)
        else $error("bus not floating");
    a_drive: assert property (p_drive)
        else $error("bus not driven");
    a_hold_busy: assert property (p_hold_busy)
        else $error("hold without busy");
    a_latch_wait: assert property (p_latch_wait)
        else $error("busy ended before latch");
    a_no_restart: assert property (p_no_restart)
        else $error("restart while busy");
    a_hold_len: assert property (p_hold_len)
        else $error("hold length wrong");
    a_ready: assert property (p_ready)
        else $error("core taken outside hold");
    a_nat: assert property (p_nat)
        else $error("bus wrong at busy rise");
    a_swap: assert property (p_swap)
        else $error("swapped bus wrong at busy rise");
endmodule // acp_port_asserts
`default_nettype wire

// ==== sim/acp_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Converter core stand-in
// ----------------------------------------
module acp_core_model (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        hold,
    input wire logic        core_ready,
    input wire logic        slow,
    input wire logic [15:0] word,
    output logic [15:0]     core_code,
    output logic            core_valid
);
    logic [2:0] dly;
    logic       done;
    // One word per hold; slow answer still lands inside the 20-cycle hold, before the latch
    always_ff @(posedge mclk) begin
        if (sys_rst || !hold) begin
            dly        <= 3'h0;
            done       <= 1'b0;
            core_valid <= 1'b0;
            core_code  <= 16'h5a5a;
        end else if (core_valid && core_ready) begin
            done       <= 1'b1;
            core_valid <= 1'b0;
            core_code  <= ~core_code;
        end else if (!done && !core_valid) begin
            dly <= dly + 3'h1;
            if (dly == (slow ? 3'h5 : 3'h1)) begin
                core_valid <= 1'b1;
                core_code  <= word;
            end
        end
    end
endmodule // acp_core_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cs_n = 1'b1;
    logic        rc = 1'b1;
    logic        byte_sel = 1'b0;
    logic        slow = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [15:0] core_code;
    logic        core_valid;
    logic        core_ready;
    logic        hold;
    logic        busy_n;
    logic [15:0] result_bus_o;
    logic [15:0] result_bus_oe_n;
    int          errors = 0;
    int          comparisons = 0;

    acp_port #(.CONV_CYCLES(20)) uut (.mclk, .sys_rst, .cs_n, .rc, .byte_sel, .core_code,
        .core_valid, .core_ready, .hold, .busy_n, .result_bus_o, .result_bus_oe_n);
    acp_core_model u_core (.mclk, .sys_rst, .hold, .core_ready, .slow, .word, .core_code,
        .core_valid);

    always #5 mclk = ~mclk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Pins low for six cycles, then wait a bounded time for busy to end
    task automatic convert(input logic via_cs, input logic [15:0] w);
        int n;
        word = w;
        if (via_cs) begin
            rc = 1'b0;
        end else begin
            cs_n = 1'b0;
        end
        step(1);
        if (via_cs) begin
            cs_n = 1'b0;
        end else begin
            rc = 1'b0;
        end
        step(6);
        rc = 1'b1;
        cs_n = via_cs;
        step(1);
        chk("busy_n low", 16'h0000, {15'h0, busy_n});
        n = 0;
        while (busy_n !== 1'b1 && n < 60) begin
            step(1);
            n++;
        end
        chk("busy_n rise", 16'h0001, {15'h0, busy_n});
    endtask
    task automatic t_rc_mode();
        cs_n = 1'b0;
        convert(1'b0, 16'h8001);
        chk("bus at busy rise", 16'h8001, result_bus_o);
        chk("drive", 16'h0000, result_bus_oe_n);
        byte_sel = 1'b1;
        step(4);
        chk("swapped", 16'h0180, result_bus_o);
        byte_sel = 1'b0;
        step(4);
        chk("natural", 16'h8001, result_bus_o);
        rc = 1'b0;
        step(4);
        chk("float rc low", 16'hffff, result_bus_oe_n);
        rc = 1'b1;
        step(4);
        chk("short pulse", 16'h0001, {15'h0, busy_n});
        $display("test rc_mode done");
    endtask
    task automatic t_cs_mode();
        cs_n = 1'b1;
        slow = 1'b1;
        step(4);
        convert(1'b1, 16'h7ffe);
        chk("float cs high", 16'hffff, result_bus_oe_n);
        cs_n = 1'b0;
        step(4);
        chk("cs read", 16'h7ffe, result_bus_o);
        chk("cs drive", 16'h0000, result_bus_oe_n);
        slow = 1'b0;
        $display("test cs_mode done");
    endtask
    // Second start lands inside the busy window and must be dropped
    task automatic t_busy_ignore();
        word = 16'h1234;
        byte_sel = 1'b1;
        rc = 1'b0;
        step(6);
        rc = 1'b1;
        step(2);
        rc = 1'b0;
        step(6);
        rc = 1'b1;
        chk("busy in restart", 16'h0000, {15'h0, busy_n});
        step(20);
        chk("one conversion", 16'h0001, {15'h0, busy_n});
        chk("result kept", 16'h3412, result_bus_o);
        byte_sel = 1'b0;
        $display("test busy_ignore done");
    endtask
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        step(20);
        sys_rst = 1'b0;
        step(2);
        chk("reset float", 16'hffff, result_bus_oe_n);
        chk("reset busy", 16'h0001, {15'h0, busy_n});
        t_rc_mode();
        t_cs_mode();
        t_busy_ignore();
        final_report();
    end
    // Run needs under 700 cycles
    initial begin
        #20000;
        errors++;
        final_report();
    end
endmodule // testbench
bind acp_port acp_port_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_asserts (.mclk, .sys_rst,
    .cs_n, .rc, .byte_sel, .core_code, .core_valid, .core_ready, .hold, .busy_n,
    .result_bus_o, .result_bus_oe_n);
`default_nettype wire
